// *** rtl/csif_params.svh ***
// Register offsets, field positions, reset values and timing counts for the status bank
`ifndef CSIF_PARAMS_SVH
`define CSIF_PARAMS_SVH
`define CSIF_ADDR_CMD_STATUS 8'h11
`define CSIF_ADDR_READY_FLAGS 8'h12
`define CSIF_ADDR_IRQ_ENABLE 8'h0F
`define CSIF_BIT_INIT_POSTPROC 7
`define CSIF_BIT_CONVERTING 6
`define CSIF_BIT_SLEEPING 5
`define CSIF_BIT_CMD_ERR 4
`define CSIF_CTR_RESET 4'h0
`define CSIF_ERR_BAD_CMD 4'h0
`define CSIF_ERR_BAD_PARAM 4'h1
`define CSIF_ERR_SATURATE 4'h2
`define CSIF_ERR_OUT_OVF 4'h3
`define CSIF_READY_RESET 6'h00
`define CSIF_INIT_TIME_NS 1000
`define CSIF_INIT_CYCLES ((`CSIF_INIT_TIME_NS + 4) / 5)
`endif

// *** rtl/csif_pkg.sv ***
// Types shared by the status bank files
package csif_pkg;
  typedef enum logic [1:0] {
    CSIF_ST_INIT,
    CSIF_ST_SLEEP,
    CSIF_ST_CONVERT,
    CSIF_ST_POSTPROC
  } csif_power_e;

  typedef struct packed {
    logic cmd_ok;
    logic cmd_bad;
    logic param_bad;
    logic saturate;
    logic out_ovf;
    logic counter_clear;
    logic soft_reset;
  } csif_cmd_evt_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csif_reg_req_s;
endpackage

// *** rtl/csif_ready_flags.sv ***
// Per-channel result-ready flags, cleared by a read
`timescale 1ns/10ps
`default_nettype none
module csif_ready_flags #(
  parameter int NCH = 6
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  // Events
  input wire logic [NCH-1:0] result_ready,
  input wire logic clear_read,
  // State
  output logic [NCH-1:0] flags
);
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_flag
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          flags[g] <= 1'b0;
        else if (result_ready[g])
          flags[g] <= 1'b1; // RULE14 RULE19
        else if (clear_read || soft_reset)
          flags[g] <= 1'b0; // RULE15
      end
    end
  endgenerate
endmodule // csif_ready_flags
`default_nettype wire

// *** rtl/csif_status_bank.sv ***
// Command-status and channel ready-flag registers of the sensor host register space
// Summary of operation
// RULE1: Bit 7 high while initializing or post-processing
// RULE2: Bit 6 high during conversion
// RULE3: Bit 5 high while sleeping
// RULE4: Bit 4 set on command error
// RULE5: Counter field shows error code when errored
// RULE6: Soft reset or counter clear clears error
// RULE7: Counter increments per successful command
// RULE8: Counter zeroed by clear, reset, soft reset
// RULE9: Host detects completion by counter change
// RULE10: Bad command code 0, bad parameter 1
// RULE11: Saturation or overflow gives code 2
// RULE12: Output space overflow gives code 3
// RULE13: After reset initializing, then sleeping
// RULE14: Ready flag n set on channel result
// RULE15: Reading ready register clears all flags
// RULE16: Channel interrupt only when enabled
// RULE17: Host polls status until change or error
// RULE18: Counter wraps fifteen to zero silently
// RULE19: Ready event beats a clearing read
`timescale 1ns/10ps
`default_nettype none
`include "csif_params.svh"
module csif_status_bank
  import csif_pkg::*;
#(
  parameter int NCH = 6,
  parameter int INIT_CYCLES = `CSIF_INIT_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register access from the host-interface logic
  input wire csif_pkg::csif_reg_req_s req,
  output logic [7:0] rdata,
  // Command executor events
  input wire csif_pkg::csif_cmd_evt_s cmd_evt,
  // Measurement engine status
  input wire logic conv_busy,
  input wire logic postproc_busy,
  input wire logic [NCH-1:0] result_ready,
  // Interrupt pin, active low open drain
  output logic irq_n_out,
  output logic irq_n_oe
);

  import csif_pkg::*;

  // Power state and initialization timer
  csif_power_e pstate_r;
  csif_power_e run_state;
  logic [15:0] init_cnt_r;
  logic init_done;

  logic st_init_or_postproc_flag;
  logic st_converting;
  logic st_sleeping;

  // Command error flag and counter or error-code field
  logic err_r;
  logic [3:0] ctr_r;
  logic [3:0] ctr_inc;
  logic err_hit;
  logic [3:0] err_code;
  logic ctr_clear;

  // Channel enables, ready flags and pending interrupts
  logic [NCH-1:0] ie_r;
  logic [NCH-1:0] flags;
  logic [NCH-1:0] pend;
  logic any_pend;

  // Register access decode and read path
  logic sel_status;
  logic sel_ready;
  logic sel_enable;
  logic sel_none;

  logic [7:0] status;
  logic [7:0] ready_byte;
  logic [7:0] enable_byte;
  logic [7:0] rdata_nxt;
  logic rd_ready;
  logic wr_enable;
  logic srst;

  // Soft reset returns every register here except the read data, irq_n_oe and any ready flag set in that same cycle to its power-up state
  assign srst = cmd_evt.soft_reset;
  // Either clear command drops the error flag and zeroes the field
  assign ctr_clear = srst || cmd_evt.counter_clear;
  assign ctr_inc = ctr_r + 4'h1;

  // Strobes qualified by address
  assign rd_ready = req.rd && sel_ready;
  assign wr_enable = req.wr && sel_enable;
  // Timer parks at its last count once initialization is over
  assign init_done = (init_cnt_r == 16'(INIT_CYCLES - 1));

  // Status bits decoded from the power state
  assign st_init_or_postproc_flag = (pstate_r == CSIF_ST_INIT) || (pstate_r == CSIF_ST_POSTPROC);
  assign st_converting = (pstate_r == CSIF_ST_CONVERT);
  assign st_sleeping = (pstate_r == CSIF_ST_SLEEP);

  // Address decode for the registers kept in this bank
  always_comb
  begin
    sel_status = 1'b0;
    sel_ready = 1'b0;
    sel_enable = 1'b0;
    sel_none = 1'b0;
    if (req.addr == `CSIF_ADDR_CMD_STATUS)
      sel_status = 1'b1;
    else if (req.addr == `CSIF_ADDR_READY_FLAGS)
      sel_ready = 1'b1;
    else if (req.addr == `CSIF_ADDR_IRQ_ENABLE)
      sel_enable = 1'b1;
    else
      sel_none = 1'b1;
  end

  // Initialization timer; restarts on every soft reset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      init_cnt_r <= 16'h0000;
    else if (srst)
      init_cnt_r <= 16'h0000;
    else if ((pstate_r == CSIF_ST_INIT) && !init_done)
      init_cnt_r <= init_cnt_r + 16'h0001;
  end

  // Operating state from the engine's busy levels; conversion wins
  always_comb
  begin
    run_state = CSIF_ST_SLEEP;
    if (conv_busy)
      run_state = CSIF_ST_CONVERT;
    else if (postproc_busy)
      run_state = CSIF_ST_POSTPROC;
  end

  // Power state; soft reset re-enters initialization
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pstate_r <= CSIF_ST_INIT; // RULE13
    else if (srst)
      pstate_r <= CSIF_ST_INIT; // RULE13
    else
    begin
      case (pstate_r)
        CSIF_ST_INIT:
        begin
          if (init_done)
            pstate_r <= CSIF_ST_SLEEP; // RULE13
        end
        CSIF_ST_SLEEP,
        CSIF_ST_CONVERT,
        CSIF_ST_POSTPROC:
          pstate_r <= run_state;
        // Unused encoding; restart initialization
        default:
          pstate_r <= CSIF_ST_INIT;
      endcase
    end
  end

  // Error source priority: unknown command first, output overflow last
  always_comb
  begin
    err_hit = 1'b1;
    err_code = `CSIF_ERR_BAD_CMD;
    if (cmd_evt.cmd_bad)
      err_code = `CSIF_ERR_BAD_CMD; // RULE10
    else if (cmd_evt.param_bad)
      err_code = `CSIF_ERR_BAD_PARAM; // RULE10
    else if (cmd_evt.saturate)
      err_code = `CSIF_ERR_SATURATE; // RULE11
    else if (cmd_evt.out_ovf)
      err_code = `CSIF_ERR_OUT_OVF; // RULE12
    else
      err_hit = 1'b0;
  end

  // Error flag; a clear command outranks a new error in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      err_r <= 1'b0;
    else if (ctr_clear)
      err_r <= 1'b0; // RULE6
    else if (err_hit)
      err_r <= 1'b1; // RULE4
  end

  // Counter field; holds the error code while the flag is up
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ctr_r <= `CSIF_CTR_RESET; // RULE8
    else if (ctr_clear)
      ctr_r <= `CSIF_CTR_RESET; // RULE8
    else if (err_hit)
      ctr_r <= err_code; // RULE5
    // Wraps from fifteen to zero without flagging an error
    else if (cmd_evt.cmd_ok && !err_r)
      ctr_r <= ctr_inc; // RULE7 RULE18
  end

  // Channel interrupt enables, one flip-flop per channel
  genvar g;

  generate
    for (g = 0; g < NCH; g++)
    begin : g_chan
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          ie_r[g] <= 1'b0;
        else if (srst)
          ie_r[g] <= 1'b0;
        else if (wr_enable)
          ie_r[g] <= req.wdata[g];
      end

      assign pend[g] = flags[g] & ie_r[g]; // RULE16
    end
  endgenerate

  assign any_pend = |pend;

  csif_ready_flags #(
    .NCH(NCH)
  ) u_flags (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .soft_reset(srst),
    .result_ready(result_ready),
    .clear_read(rd_ready),
    .flags(flags)
  );

  // Register bytes; bits above the channel count read as zero
  always_comb
  begin
    ready_byte = 8'h00;
    enable_byte = 8'h00;
    ready_byte[NCH-1:0] = flags;
    enable_byte[NCH-1:0] = ie_r;
  end

  // Command-status byte assembled from live state
  always_comb
  begin
    status = 8'h00;
    status[`CSIF_BIT_INIT_POSTPROC] = st_init_or_postproc_flag; // RULE1
    status[`CSIF_BIT_CONVERTING] = st_converting; // RULE2
    status[`CSIF_BIT_SLEEPING] = st_sleeping; // RULE3
    status[`CSIF_BIT_CMD_ERR] = err_r; // RULE4
    status[3:0] = ctr_r; // RULE5 RULE9
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (sel_status)
      rdata_nxt = status; // RULE17
    else if (sel_ready)
      rdata_nxt = ready_byte; // RULE14
    else if (sel_enable)
      rdata_nxt = enable_byte;
    else if (sel_none)
      rdata_nxt = 8'h00;
  end

  // Registered read data, valid the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= 8'h00;
    else if (req.rd)
      rdata <= rdata_nxt;
  end

  // Open-drain pin: the level is always low, the enable carries the interrupt
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_n_out <= 1'b0;
    else
      irq_n_out <= 1'b0;
  end

  // Pin driven (enable low) while any enabled flag is pending
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_n_oe <= 1'b1;
    else
      irq_n_oe <= ~any_pend; // RULE16
  end
endmodule // csif_status_bank
`default_nettype wire

// *** tb/csif_host_model.sv ***
// Host controller model issuing register reads and writes
`timescale 1ns/10ps
`default_nettype none
module csif_host_model
  import csif_pkg::*;
(
  // Clock and returned data
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  // Register request
  output csif_pkg::csif_reg_req_s req
);
  initial req = '0;
  // One-cycle strobe; read data is taken one edge after it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] wd,
                     output logic [7:0] q);
    @(posedge ref_clk) req <= {~w, w, a, wd};
    @(posedge ref_clk) req <= '0;
    #1 q = rdata;
  endtask
endmodule // csif_host_model
`default_nettype wire

// *** tb/csif_status_bank_asserts.sv ***
// Checker for the status bank ports
`timescale 1ns/10ps
`default_nettype none
module csif_status_bank_asserts
  import csif_pkg::*;
#(parameter int NCH = 6) (
  // Watched ports
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire csif_pkg::csif_reg_req_s req,
  input wire logic [7:0] rdata,
  input wire csif_pkg::csif_cmd_evt_s cmd_evt,
  input wire logic conv_busy,
  input wire logic postproc_busy,
  input wire logic [NCH-1:0] result_ready,
  input wire logic irq_n_out,
  input wire logic irq_n_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence rd_s(a);
    req.rd && req.addr == a;
  endsequence
  hold_a: assert property (!req.rd && !cmd_evt.soft_reset |=> $stable(rdata))
    else $error("read data moved");
  rsvd_a: assert property (rd_s(8'h12) |=> rdata[7:6] == 2'b00)
    else $error("reserved ready bits set");
  unmap_a: assert property (rd_s(8'h20) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  conv_a: assert property (req.rd && req.addr == 8'h11 && conv_busy && $past(conv_busy)
    |=> rdata[6])
    else $error("convert bit low");
  post_a: assert property (req.rd && req.addr == 8'h11 && postproc_busy && !conv_busy
    && $past(postproc_busy && !conv_busy) |=> rdata[7:5] == 3'b100)
    else $error("postproc bits wrong");
  code_a: assert property (cmd_evt == 7'b0010000 ##2 rd_s(8'h11) |=> rdata[4:0] == 5'h11)
    else $error("param error code wrong");
  clr_a: assert property (cmd_evt.counter_clear ##2 rd_s(8'h11) |=> rdata[4:0] == 5'h00)
    else $error("counter clear missed");
  rclr_a: assert property (req.rd && req.addr == 8'h12 && result_ready == 0
    ##1 result_ready == 0
    ##1 req.rd && req.addr == 8'h12 && result_ready == 0 |=> rdata[5:0] == 6'h00)
    else $error("ready flags not cleared");
  keep_a: assert property (req.rd && req.addr == 8'h12 && result_ready[0] ##1 !result_ready[0]
    ##1 rd_s(8'h12) |=> rdata[0])
    else $error("ready event lost");
  irq_a: assert property (irq_n_out == 1'b0)
    else $error("irq pin driven high");
endmodule // csif_status_bank_asserts
bind csif_status_bank csif_status_bank_asserts #(.NCH(NCH)) u_chk (.*);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the status bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import csif_pkg::*;
  logic ref_clk = 0, reset_n = 0, conv_busy = 0, postproc_busy = 0, irq_n_out, irq_n_oe;
  logic [5:0] result_ready = '0, m;
  logic [7:0] rdata, d;
  csif_cmd_evt_s cmd_evt = '0;
  csif_reg_req_s req;
  int err_count = 0, samples_checked = 0, cyc = 0, ctr = 0;
  initial forever #2.5 ref_clk = ~ref_clk;
  csif_status_bank #(.INIT_CYCLES(4)) dut (.*);
  csif_host_model host (.*);
  task automatic results();
    $display("Checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("Error at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic st(input logic [7:0] e);
    host.acc(1'b0, 8'h11, 8'h00, d);
    chk(e, d);
  endtask
  task automatic ev(input logic [6:0] v);
    @(posedge ref_clk) cmd_evt <= v;
    @(posedge ref_clk) cmd_evt <= '0;
  endtask
  task automatic pulse(input logic [5:0] v);
    @(posedge ref_clk) result_ready <= v;
    @(posedge ref_clk) result_ready <= '0;
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      results();
    end
  end
  initial
  begin
    void'($urandom(32'h50696d9e));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    st(8'h80);
    repeat (6) @(posedge ref_clk);
    st(8'h20);
    for (int i = 0; i < 17; i++)
    begin
      ev(7'h40);
      ctr = (ctr + 1) % 16;
      st(8'h20 | ctr[3:0]);
    end
    $display("Test counter done");
    for (int k = 0; k < 4; k++)
    begin
      ev(7'h20 >> k);
      st(8'h30 | k[3:0]);
      ev(7'h40);
      st(8'h30 | k[3:0]);
      ev(7'h02 >> (k % 2));
      st((k % 2) ? 8'h80 : 8'h20);
      repeat (6) @(posedge ref_clk);
    end
    $display("Test errors done");
    @(posedge ref_clk) {conv_busy, postproc_busy} <= 2'b11;
    st(8'h40);
    @(posedge ref_clk) conv_busy <= 1'b0;
    st(8'h80);
    @(posedge ref_clk) postproc_busy <= 1'b0;
    st(8'h20);
    $display("Test power done");
    host.acc(1'b1, 8'h0F, 8'h3F, d);
    m = 6'($urandom) | 6'h01;
    pulse(m);
    repeat (2) @(posedge ref_clk);
    #1 chk(8'h00, {7'h00, irq_n_oe});
    host.acc(1'b0, 8'h12, 8'h00, d);
    chk({2'b00, m}, d);
    fork
      host.acc(1'b0, 8'h12, 8'h00, d);
      pulse(6'h01);
    join
    host.acc(1'b0, 8'h12, 8'h00, d);
    chk(8'h01, d);
    host.acc(1'b0, 8'h12, 8'h00, d);
    chk(8'h00, d);
    @(posedge ref_clk);
    #1 chk(8'h01, {7'h00, irq_n_oe});
    host.acc(1'b1, 8'h0F, 8'h00, d);
    pulse(m);
    repeat (2) @(posedge ref_clk);
    #1 chk(8'h01, {7'h00, irq_n_oe});
    host.acc(1'b0, 8'h20, 8'h00, d);
    chk(8'h00, d);
    $display("Test ready flags done");
    results();
  end
endmodule // testbench
`default_nettype wire
